// *** hw/gpio_upper_pin_config.sv ***
// Upper pin configuration block: registers for pins 12 to 15, low mode byte,
// pin output selection and input conditioning.
// Assumes register strobes and internal status inputs are synchronous to mclk;
// pin inputs are asynchronous.
//
// Function
// - Passive-to-active edge wakes unless suppressed
// - Type bit selects input polarity and rail
// - Pin 13 drives feedback, push-pull or open-drain
// - Pin 13 code 01 is regulator-capable input
// - Code 11 on 12-14 is push-pull mode output
// - Pin 12 fault output or input
// - Pin 12 code 10 follows voltage monitor
// - Pins 14,15 blink open-drain or input
// - Pin 15 clock line when pin 14 assigns
// - Pin 15 code 11 open-drain mode output
// - Pin 14 code 10 data, pin 15 clock
// - Input mode bit enables debouncing
// - Output mode bit sets output level
// - Mode bit sets sequencer output polarity
`timescale 1ns/1ps
`default_nettype none
module gpio_upper_pin_config
  import gpio_upper_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n,
  output logic [3:0] rail_two_sel,
  input wire logic [3:0] upper_mode_bits,
  input wire logic supply_fault_low,
  input wire logic system_voltage_alert,
  input wire logic feedback_signal_one,
  input wire logic blink14_on,
  input wire logic blink15_on,
  input wire logic twowire_data_low,
  input wire logic twowire_clk_low,
  output logic twowire_enable,
  output logic twowire_data_in,
  output logic twowire_clk_in,
  output logic [3:0] pin_input_active,
  output logic [3:0] pin_wake,
  output logic wake_request,
  output logic pin13_regulator_ctrl,
  output logic [7:0] low_pin_mode,
  input wire logic [3:0] seq_state,
  output logic [3:0] seq_drive
);

  // Output level for an active state at the chosen polarity
  function automatic logic pol(input logic state, input logic act_high);
    pol = act_high ? state : ~state;
  endfunction

  // ==========================================================================
  // Registers
  logic [7:0] cfg_lo_r;
  logic [7:0] cfg_hi_r;
  logic [7:0] mode_r;
  logic [7:0] rdata_r;
  logic [3:0] out_r;
  logic [3:0] oe_n_r;
  logic [3:0] seq_r;

  wire hit_lo = reg_addr == ADDR_PIN_CONFIG_12_13;
  wire hit_hi = reg_addr == ADDR_PIN_CONFIG_14_15;
  wire hit_mode = reg_addr == ADDR_PIN_MODE_LOW_BYTE;
  wire [7:0] rdata_nxt = hit_lo ? cfg_lo_r :
                         hit_hi ? cfg_hi_r :
                         hit_mode ? mode_r : RDATA_UNMAPPED;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cfg_lo_r <= RST_PIN_CONFIG;
      cfg_hi_r <= RST_PIN_CONFIG;
      mode_r <= RST_PIN_MODE_LOW;
      rdata_r <= RDATA_UNMAPPED;
    end
    else
    begin
      if (reg_we && hit_lo)
      begin
        cfg_lo_r <= reg_wdata;
      end
      if (reg_we && hit_hi)
      begin
        cfg_hi_r <= reg_wdata;
      end
      if (reg_we && hit_mode)
      begin
        mode_r <= reg_wdata;
      end
      if (reg_re)
      begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================================
  // Field decode
  wire [1:0] f12 = cfg_lo_r[FN_LO_POS+:2];
  wire [1:0] f13 = cfg_lo_r[FN_HI_POS+:2];
  wire [1:0] f14 = cfg_hi_r[FN_LO_POS+:2];
  wire [1:0] f15 = cfg_hi_r[FN_HI_POS+:2];
  wire [3:0] fn_in = {f15 == FN_INPUT, f14 == FN_INPUT, f13 == FN_INPUT, f12 == FN_INPUT};
  wire [3:0] type_bits = {cfg_hi_r[TYPE_HI_POS], cfg_hi_r[TYPE_LO_POS],
                          cfg_lo_r[TYPE_HI_POS], cfg_lo_r[TYPE_LO_POS]};
  wire [3:0] wsup_bits = {cfg_hi_r[WSUP_HI_POS], cfg_hi_r[WSUP_LO_POS],
                          cfg_lo_r[WSUP_HI_POS], cfg_lo_r[WSUP_LO_POS]};
  wire [3:0] m = upper_mode_bits;
  wire tw_en = f14 == FN_ALT;
  wire fault_on = ~supply_fault_low;

  // ==========================================================================
  // Output selection per pin: level, drive and open-drain
  wire v12 = (f12 == FN_SOURCE) ? pol(fault_on, m[0]) :
             (f12 == FN_ALT) ? pol(system_voltage_alert, m[0]) : m[0];
  wire d12 = f12 != FN_INPUT;
  wire v13 = (f13 == FN_MODE) ? m[1] : pol(feedback_signal_one, m[1]);
  wire d13 = f13 != FN_INPUT;
  wire od13 = f13 == FN_ALT;
  wire v14 = (f14 == FN_SOURCE) ? pol(blink14_on, ~m[2]) :
             (f14 == FN_ALT) ? ~twowire_data_low : m[2];
  wire d14 = f14 != FN_INPUT;
  wire od14 = f14 != FN_MODE;
  wire v15 = (f15 == FN_SOURCE) ? pol(blink15_on, ~m[3]) :
             (f15 == FN_ALT) ? ~twowire_clk_low : m[3];
  wire d15 = (f15 != FN_INPUT) && (f15 != FN_ALT || tw_en);

  wire [3:0] val = {v15, v14, v13, v12};
  wire [3:0] drv = {d15, d14, d13, d12};
  wire [3:0] od = {1'b1, od14, od13, 1'b0};
  wire [3:0] oe_n_nxt = ~(drv & (~od | ~val));

  wire [3:0] seq_mode = {mode_r[MODE_PIN7_POS], mode_r[MODE_PIN6_POS],
                         mode_r[MODE_PIN4_POS], mode_r[MODE_PIN3_POS]};
  wire [3:0] seq_nxt = ~(seq_state ^ seq_mode);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      out_r <= 4'h0;
      oe_n_r <= 4'hf;
      seq_r <= 4'h0;
    end
    else
    begin
      out_r <= val;
      oe_n_r <= oe_n_nxt;
      seq_r <= seq_nxt;
    end
  end

  assign pin_out = out_r;
  assign pin_oe_n = oe_n_r;
  assign seq_drive = seq_r;
  assign rail_two_sel = type_bits;
  assign low_pin_mode = mode_r;

  // ==========================================================================
  // Input conditioning
  pin_cond_if pc[4] ();
  logic [3:0] sync_lvl;
  logic [3:0] act;
  logic [3:0] wk;

  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    assign pc[i].raw_pin = pin_in[i];
    assign pc[i].is_input = fn_in[i];
    assign pc[i].debounce_en = m[i];
    assign pc[i].active_high = type_bits[i];
    assign pc[i].wake_suppress = wsup_bits[i];
    assign sync_lvl[i] = pc[i].sync_level;
    assign act[i] = pc[i].active;
    assign wk[i] = pc[i].wake;
    pin_input_cond u_cond
    (
      .mclk(mclk),
      .rst(rst),
      .pc(pc[i])
    );
  end

  assign pin_input_active = act & fn_in;
  assign pin_wake = wk;
  assign wake_request = |wk;
  assign pin13_regulator_ctrl = fn_in[1] & act[1];
  assign twowire_enable = tw_en;
  assign twowire_data_in = tw_en & sync_lvl[2];
  assign twowire_clk_in = tw_en & sync_lvl[3];

  // ==========================================================================
  // Checks
  AST_P13_PUSHPULL: assert property (@(posedge mclk) disable iff (rst)
    $past(f13 == FN_SOURCE) |-> !pin_oe_n[1] && pin_out[1] == $past(pol(feedback_signal_one, m[1])))
    else $error("pin 13 push-pull feedback wrong");
  AST_P13_OPEN_DRAIN: assert property (@(posedge mclk) disable iff (rst)
    $past(f13 == FN_ALT) |-> pin_oe_n[1] == $past(pol(feedback_signal_one, m[1])))
    else $error("pin 13 open-drain feedback wrong");
  AST_P13_INPUT: assert property (@(posedge mclk) disable iff (rst)
    $past(f13 == FN_INPUT) && f13 == FN_INPUT |-> pin_oe_n[1] && (pin13_regulator_ctrl == act[1]))
    else $error("pin 13 input drives pin");
  AST_P12_MODE_OUT: assert property (@(posedge mclk) disable iff (rst)
    $past(f12 == FN_MODE) |-> !pin_oe_n[0] && pin_out[0] == $past(m[0]))
    else $error("pin 12 mode output level wrong");
  AST_P14_MODE_OUT: assert property (@(posedge mclk) disable iff (rst)
    $past(f14 == FN_MODE) |-> !pin_oe_n[2] && pin_out[2] == $past(m[2]))
    else $error("pin 14 mode output level wrong");
  AST_P12_FAULT: assert property (@(posedge mclk) disable iff (rst)
    $past(f12 == FN_SOURCE) |-> !pin_oe_n[0] && pin_out[0] == $past(pol(fault_on, m[0])))
    else $error("pin 12 fault output wrong");
  AST_P12_MONITOR: assert property (@(posedge mclk) disable iff (rst)
    $past(f12 == FN_ALT) |-> !pin_oe_n[0] && pin_out[0] == $past(pol(system_voltage_alert, m[0])))
    else $error("pin 12 monitor output wrong");
  AST_P15_BLINK: assert property (@(posedge mclk) disable iff (rst)
    $past(f15 == FN_SOURCE) |-> pin_oe_n[3] == $past(pol(blink15_on, ~m[3])))
    else $error("pin 15 blink drive wrong");
  AST_P15_CLOCK: assert property (@(posedge mclk) disable iff (rst)
    $past(f15 == FN_ALT) |-> pin_oe_n[3] == ($past(!tw_en) || !$past(twowire_clk_low)))
    else $error("pin 15 clock line wrong");
  AST_P14_DATA: assert property (@(posedge mclk) disable iff (rst)
    $past(f14 == FN_ALT) |-> pin_oe_n[2] == !$past(twowire_data_low))
    else $error("pin 14 data line wrong");
  AST_P15_MODE_OD: assert property (@(posedge mclk) disable iff (rst)
    $past(f15 == FN_MODE) |-> pin_oe_n[3] == $past(m[3]))
    else $error("pin 15 open-drain mode output wrong");
  AST_SEQ_POL: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) |-> seq_drive[2] == ($past(seq_state[2]) == $past(mode_r[MODE_PIN6_POS])))
    else $error("sequencer polarity wrong");
  AST_WRITE_EFFECT: assert property (@(posedge mclk) disable iff (rst)
    reg_we && hit_hi && reg_wdata[FN_HI_POS+:2] == FN_INPUT |=> cfg_hi_r == $past(reg_wdata) ##1 pin_oe_n[3])
    else $error("register write did not take effect");

  // ==========================================================================
  // Checks: released inputs, open-drain levels, wake gating and register path
  AST_P12_INPUT: assert property (@(posedge mclk) disable iff (rst)
    $past(f12 == FN_INPUT) |-> pin_oe_n[0])
    else $error("pin 12 input drives pin");
  AST_P14_INPUT: assert property (@(posedge mclk) disable iff (rst)
    $past(f14 == FN_INPUT) |-> pin_oe_n[2])
    else $error("pin 14 input drives pin");
  AST_P15_INPUT: assert property (@(posedge mclk) disable iff (rst)
    $past(f15 == FN_INPUT) |-> pin_oe_n[3])
    else $error("pin 15 input drives pin");
  AST_P14_BLINK: assert property (@(posedge mclk) disable iff (rst)
    $past(f14 == FN_SOURCE) |-> pin_oe_n[2] == $past(pol(blink14_on, ~m[2])))
    else $error("pin 14 blink drive wrong");
  AST_P13_MODE_OUT: assert property (@(posedge mclk) disable iff (rst)
    $past(f13 == FN_MODE) |-> !pin_oe_n[1] && pin_out[1] == $past(m[1]))
    else $error("pin 13 mode output level wrong");
  AST_P15_OD_LOW: assert property (@(posedge mclk) disable iff (rst)
    !pin_oe_n[3] |-> !pin_out[3])
    else $error("pin 15 driven high");
  AST_P14_OD_LOW: assert property (@(posedge mclk) disable iff (rst)
    $past(f14 != FN_MODE) && !pin_oe_n[2] |-> !pin_out[2])
    else $error("pin 14 open-drain driven high");
  AST_P15_CLK_OFF: assert property (@(posedge mclk) disable iff (rst)
    $past(f15 == FN_ALT && f14 != FN_ALT) |-> pin_oe_n[3])
    else $error("pin 15 clock driven without data assignment");
  AST_TWOWIRE_FOLLOW: assert property (@(posedge mclk) disable iff (rst)
    f14 == FN_ALT && !$past(rst, 2) |-> twowire_data_in == $past(pin_in[2], 2))
    else $error("two-wire data input does not follow pin 14");
  AST_RAIL_FOLLOW_LO: assert property (@(posedge mclk) disable iff (rst)
    $past(reg_we && hit_lo) |-> rail_two_sel[0] == $past(reg_wdata[TYPE_LO_POS]))
    else $error("pin 12 rail select wrong");
  AST_RAIL_FOLLOW_HI: assert property (@(posedge mclk) disable iff (rst)
    $past(reg_we && hit_hi) |-> rail_two_sel[3] == $past(reg_wdata[TYPE_HI_POS]))
    else $error("pin 15 rail select wrong");
  AST_WAKE_GATE_12: assert property (@(posedge mclk) disable iff (rst)
    pin_wake[0] |-> $past(f12 == FN_INPUT) && !$past(cfg_lo_r[WSUP_LO_POS]))
    else $error("pin 12 wake while not an enabled input");
  AST_WAKE_GATE_14: assert property (@(posedge mclk) disable iff (rst)
    pin_wake[2] |-> $past(f14 == FN_INPUT) && !$past(cfg_hi_r[WSUP_LO_POS]))
    else $error("pin 14 wake while not an enabled input");
  AST_SEQ_POL_PIN3: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) |-> seq_drive[0] == ($past(seq_state[0]) == $past(mode_r[MODE_PIN3_POS])))
    else $error("pin 3 sequencer polarity wrong");
  AST_SEQ_POL_PIN7: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) |-> seq_drive[3] == ($past(seq_state[3]) == $past(mode_r[MODE_PIN7_POS])))
    else $error("pin 7 sequencer polarity wrong");
  AST_MODE_WRITE: assert property (@(posedge mclk) disable iff (rst)
    reg_we && hit_mode |=> low_pin_mode == $past(reg_wdata))
    else $error("mode byte write did not take effect");
  AST_LO_WRITE: assert property (@(posedge mclk) disable iff (rst)
    reg_we && hit_lo && reg_wdata[FN_LO_POS+:2] == FN_INPUT |=> ##1 pin_oe_n[0])
    else $error("pin 12 input write did not release pin");
  AST_RDATA_MODE: assert property (@(posedge mclk) disable iff (rst)
    reg_re && hit_mode |=> reg_rdata == $past(mode_r))
    else $error("mode byte read wrong");

endmodule
`default_nettype wire

// *** hw/gpio_upper_pkg.sv ***
// Constants for the upper pin configuration block: register offsets, field positions,
// reset values, function codes and debounce timing.
// Assumes a single 200 MHz system clock and byte-wide register access.
`default_nettype none
package gpio_upper_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_PIN_CONFIG_12_13 = 8'h1b;
  localparam logic [7:0] ADDR_PIN_CONFIG_14_15 = 8'h1c;
  localparam logic [7:0] ADDR_PIN_MODE_LOW_BYTE = 8'h1d;

  // ==========================================================================
  // Reset values: every upper pin starts as an active-low input, wake enabled
  localparam logic [7:0] RST_PIN_CONFIG = 8'h11;
  localparam logic [7:0] RST_PIN_MODE_LOW = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ==========================================================================
  // Field positions inside a pin pair register (low pin at 0..3, high pin at 4..7)
  localparam int FN_LO_POS = 0;
  localparam int TYPE_LO_POS = 2;
  localparam int WSUP_LO_POS = 3;
  localparam int FN_HI_POS = 4;
  localparam int TYPE_HI_POS = 6;
  localparam int WSUP_HI_POS = 7;

  // Pin function codes
  localparam logic [1:0] FN_SOURCE = 2'h0;
  localparam logic [1:0] FN_INPUT = 2'h1;
  localparam logic [1:0] FN_ALT = 2'h2;
  localparam logic [1:0] FN_MODE = 2'h3;

  // Mode bit positions in the low mode byte for sequencer outputs
  localparam int MODE_PIN3_POS = 3;
  localparam int MODE_PIN4_POS = 4;
  localparam int MODE_PIN6_POS = 6;
  localparam int MODE_PIN7_POS = 7;

  // ==========================================================================
  // Debounce timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DEBOUNCE_TIME_NS = 10000;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int DEB_W = 12;
  localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYCLES - 1);
  localparam logic [DEB_W-1:0] DEB_ZERO = 12'h000;

endpackage
`default_nettype wire

// *** hw/pin_cond_if.sv ***
// Interface between the configuration block and one pin input conditioner.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
`default_nettype none
interface pin_cond_if;
  logic raw_pin;
  logic is_input;
  logic debounce_en;
  logic active_high;
  logic wake_suppress;
  logic sync_level;
  logic active;
  logic wake;

  modport cfg
  (
    output raw_pin, is_input, debounce_en, active_high, wake_suppress,
    input sync_level, active, wake
  );
  modport cond
  (
    input raw_pin, is_input, debounce_en, active_high, wake_suppress,
    output sync_level, active, wake
  );
endinterface
`default_nettype wire

// *** hw/pin_input_cond.sv ***
// One pin input path: synchroniser, polarity, optional debounce, wake edge detect.
// Assumes raw_pin is asynchronous to mclk; configuration comes from mclk logic.
`timescale 1ns/1ps
`default_nettype none
module pin_input_cond
  import gpio_upper_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  pin_cond_if.cond pc
);

  logic s1_r;
  logic s2_r;
  logic active_r;
  logic active_nxt;
  logic wake_r;
  logic [DEB_W-1:0] cnt_r;
  logic [DEB_W-1:0] cnt_nxt;

  // ==========================================================================
  // Polarity and debounce
  wire lvl = pc.active_high ? s2_r : ~s2_r;
  wire differs = lvl != active_r;
  wire settled = cnt_r == DEB_LAST;
  assign active_nxt = (!pc.debounce_en || (differs && settled)) ? lvl : active_r;
  assign cnt_nxt = (!pc.debounce_en || !differs || settled) ? DEB_ZERO : cnt_r + 12'h001;
  wire wake_nxt = active_nxt & ~active_r & pc.is_input & ~pc.wake_suppress;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      // Passive level of the reset polarity (both pins of a pair), so no false edge at release
      s1_r <= ~RST_PIN_CONFIG[TYPE_LO_POS];
      s2_r <= ~RST_PIN_CONFIG[TYPE_LO_POS];
      active_r <= 1'b0;
      cnt_r <= DEB_ZERO;
      wake_r <= 1'b0;
    end
    else
    begin
      s1_r <= pc.raw_pin;
      s2_r <= s1_r;
      active_r <= active_nxt;
      cnt_r <= cnt_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign pc.sync_level = s2_r;
  assign pc.active = active_r;
  assign pc.wake = wake_r;

  // ==========================================================================
  // Checks
  AST_WAKE_QUIET: assert property (@(posedge mclk) disable iff (rst)
    $past(pc.wake_suppress) |-> !wake_r)
    else $error("wake raised while suppressed");
  AST_WAKE_CAUSE: assert property (@(posedge mclk) disable iff (rst)
    wake_r |-> active_r && !$past(active_r) && $past(pc.is_input))
    else $error("wake without passive to active edge");
  AST_NO_DEBOUNCE: assert property (@(posedge mclk) disable iff (rst)
    (!pc.debounce_en ##1 !pc.debounce_en) |-> active_r == $past(lvl))
    else $error("undebounced input does not follow pin");
  AST_POLARITY: assert property (@(posedge mclk) disable iff (rst)
    !pc.debounce_en && pc.active_high |=> active_r == $past(s2_r))
    else $error("active-high input inverted");

endmodule
`default_nettype wire

// *** verif/pin_circuit_model.sv ***
// External circuits on pins 12 to 15: an optional driver per pin plus a pull-up.
// Assumes pin_oe_n low means the block drives the pin.
`timescale 1ns/1ps
`default_nettype none
module pin_circuit_model
(
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_level,
  output logic [3:0] pin_level
);
  // ==========================================================================
  // Wire level: block drive first, then the external driver, else the pull-up
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      pin_level[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_level[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// *** verif/test_gpio_upper_pin_config.sv ***
// Self-checking bench for the upper pin configuration block.
// Assumes the pin circuit model closes the loop from pin outputs to pin inputs.
`timescale 1ns/1ps
`default_nettype none
module test_gpio_upper_pin_config
  import gpio_upper_pkg::*;
;
  typedef struct packed {logic [7:0] addr; logic [7:0] data; logic [3:0] mode; logic [3:0] oe; logic [3:0] out;} row_type;
  logic mclk, rst, reg_we, reg_re, supply_fault_low, system_voltage_alert, feedback_signal_one;
  logic blink14_on, blink15_on, twowire_data_low, twowire_clk_low, twowire_enable;
  logic twowire_data_in, twowire_clk_in, wake_request, pin13_regulator_ctrl;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, low_pin_mode;
  logic [3:0] pin_in, pin_out, pin_oe_n, rail_two_sel, upper_mode_bits, pin_input_active;
  logic [3:0] pin_wake, seq_state, seq_drive, ext_en, ext_level;
  int num_errors = 0;
  int compares = 0;
  // Fault asserted, monitor alert and feedback high, blinking off
  row_type rows [15] = '{
    '{8'h1b, 8'h10, 4'h1, 4'he, 4'h1}, '{8'h1b, 8'h12, 4'h0, 4'he, 4'h0}, '{8'h1b, 8'h13, 4'h1, 4'he, 4'h1},
    '{8'h1b, 8'h01, 4'h2, 4'hd, 4'h2}, '{8'h1b, 8'h21, 4'h0, 4'hd, 4'h0}, '{8'h1b, 8'h21, 4'h2, 4'hf, 4'h0},
    '{8'h1b, 8'h31, 4'h2, 4'hd, 4'h2}, '{8'h1b, 8'h11, 4'h0, 4'hf, 4'h0}, '{8'h1c, 8'h13, 4'h0, 4'hb, 4'h0},
    '{8'h1c, 8'h10, 4'h0, 4'hb, 4'h0}, '{8'h1c, 8'h10, 4'h4, 4'hf, 4'h0}, '{8'h1c, 8'h31, 4'h0, 4'h7, 4'h0},
    '{8'h1c, 8'h31, 4'h8, 4'hf, 4'h0}, '{8'h1c, 8'h01, 4'h8, 4'hf, 4'h0}, '{8'h1c, 8'h11, 4'h0, 4'hf, 4'h0}};

  // ==========================================================================
  // Design and pin circuits
  gpio_upper_pin_config uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .rail_two_sel(rail_two_sel), .upper_mode_bits(upper_mode_bits),
    .supply_fault_low(supply_fault_low), .system_voltage_alert(system_voltage_alert),
    .feedback_signal_one(feedback_signal_one), .blink14_on(blink14_on), .blink15_on(blink15_on),
    .twowire_data_low(twowire_data_low), .twowire_clk_low(twowire_clk_low), .twowire_enable(twowire_enable),
    .twowire_data_in(twowire_data_in), .twowire_clk_in(twowire_clk_in), .pin_input_active(pin_input_active),
    .pin_wake(pin_wake), .wake_request(wake_request), .pin13_regulator_ctrl(pin13_regulator_ctrl),
    .low_pin_mode(low_pin_mode), .seq_state(seq_state), .seq_drive(seq_drive));
  pin_circuit_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_level(ext_level),
    .pin_level(pin_in));

  // ==========================================================================
  // Tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge mclk);
    reg_we = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge mclk);
    reg_re = 1'b0;
    d = reg_rdata;
  endtask

  // Moves pin 12 and counts wake pulses over the following cycles
  task automatic pin_wake_count(input logic lvl, output int c);
    @(negedge mclk);
    ext_level[0] = lvl;
    c = 0;
    repeat (8)
    begin
      @(negedge mclk);
      c += int'(pin_wake[0] === 1'b1 && wake_request === 1'b1);
    end
  endtask

  // Counts wake requests over the first cycles after a reset release
  task automatic wake_quiet(output int c);
    c = 0;
    repeat (4)
    begin
      @(negedge mclk);
      c += int'(wake_request === 1'b1);
    end
  endtask

  task automatic end_of_test;
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    #60000;
    num_errors++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [7:0] d;
    int c;
    rst = 1'b1;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    upper_mode_bits = 4'h0;
    supply_fault_low = 1'b0;
    system_voltage_alert = 1'b1;
    feedback_signal_one = 1'b1;
    blink14_on = 1'b0;
    blink15_on = 1'b0;
    twowire_data_low = 1'b0;
    twowire_clk_low = 1'b0;
    seq_state = 4'h0;
    ext_en = 4'h0;
    ext_level = 4'hf;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    chk("oe after reset", 8'h0f, {4'h0, pin_oe_n});
    wake_quiet(c);
    chk("no wake after reset", 8'h00, 8'(c));
    rd(ADDR_PIN_CONFIG_12_13, d);
    chk("cfg 12 13 reset", 8'h11, d);
    rd(ADDR_PIN_CONFIG_14_15, d);
    chk("cfg 14 15 reset", 8'h11, d);
    rd(ADDR_PIN_MODE_LOW_BYTE, d);
    chk("mode reset", 8'h00, d);
    rd(8'h1f, d);
    chk("unmapped", 8'h00, d);
    foreach (rows[i])
    begin
      upper_mode_bits = rows[i].mode;
      wr(rows[i].addr, rows[i].data);
      repeat (2) @(negedge mclk);
      chk("pin_oe_n", {4'h0, rows[i].oe}, {4'h0, pin_oe_n});
      chk("pin_out", {4'h0, rows[i].out}, {4'h0, pin_out & ~pin_oe_n});
      rd(rows[i].addr, d);
      chk("readback", rows[i].data, d);
    end
    // Wake and polarity on pin 12, regulator input on pin 13
    ext_en = 4'h3;
    ext_level = 4'h3;
    repeat (6) @(negedge mclk);
    pin_wake_count(1'b0, c);
    chk("wake on activate", 8'h01, 8'(c));
    chk("active low input", 8'h01, {7'h00, pin_input_active[0]});
    ext_level[1] = 1'b0;
    repeat (6) @(negedge mclk);
    chk("regulator ctrl", 8'h01, {7'h00, pin13_regulator_ctrl});
    pin_wake_count(1'b1, c);
    chk("no wake on release", 8'h00, 8'(c));
    wr(ADDR_PIN_CONFIG_12_13, 8'h19);
    pin_wake_count(1'b0, c);
    chk("wake suppressed", 8'h00, 8'(c));
    wr(ADDR_PIN_CONFIG_12_13, 8'h15);
    pin_wake_count(1'b1, c);
    chk("active high wake", 8'h01, 8'(c));
    // Debounce holds the old level well past the synchroniser delay
    upper_mode_bits = 4'h1;
    pin_wake_count(1'b0, c);
    chk("debounced hold", 8'h01, {7'h00, pin_input_active[0]});
    repeat (2100) @(negedge mclk);
    chk("debounced change", 8'h00, {7'h00, pin_input_active[0]});
    // Two-wire pair on pins 14 and 15
    upper_mode_bits = 4'h0;
    wr(ADDR_PIN_CONFIG_14_15, 8'h22);
    repeat (3) @(negedge mclk);
    chk("twowire enable", 8'h01, {7'h00, twowire_enable});
    chk("twowire idle", 8'h03, {6'h00, pin_oe_n[3:2]});
    chk("twowire in idle", 8'h03, {6'h00, twowire_data_in, twowire_clk_in});
    twowire_data_low = 1'b1;
    twowire_clk_low = 1'b1;
    repeat (5) @(negedge mclk);
    chk("twowire pull", 8'h00, {6'h00, pin_oe_n[3:2]});
    chk("twowire in", 8'h00, {6'h00, twowire_data_in, twowire_clk_in});
    twowire_data_low = 1'b0;
    twowire_clk_low = 1'b0;
    // Rail selection and sequencer polarity
    wr(ADDR_PIN_CONFIG_12_13, 8'h51);
    wr(ADDR_PIN_CONFIG_14_15, 8'h41);
    seq_state = 4'h5;
    wr(ADDR_PIN_MODE_LOW_BYTE, 8'h58);
    repeat (3) @(negedge mclk);
    chk("rail select", 8'h0a, {4'h0, rail_two_sel});
    chk("seq drive", 8'h0d, {4'h0, seq_drive});
    chk("low mode", 8'h58, low_pin_mode);
    // Live fault, feedback and pin 14 blink inputs reach the pins
    supply_fault_low = 1'b1;
    blink14_on = 1'b1;
    upper_mode_bits = 4'h3;
    wr(ADDR_PIN_CONFIG_12_13, 8'h00);
    wr(ADDR_PIN_CONFIG_14_15, 8'h10);
    repeat (3) @(negedge mclk);
    chk("live oe", 8'h0c, {4'h0, pin_oe_n});
    chk("live out", 8'h02, {4'h0, pin_out & ~pin_oe_n});
    // Mid-run reset with every pin at its passive level
    ext_level = 4'hf;
    rst = 1'b1;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    chk("oe after mid reset", 8'h0f, {4'h0, pin_oe_n});
    wake_quiet(c);
    chk("no wake after mid reset", 8'h00, 8'(c));
    rd(ADDR_PIN_CONFIG_14_15, d);
    chk("cfg 14 15 mid reset", 8'h11, d);
    end_of_test();
  end
endmodule
`default_nettype wire
